// File: rtl/lts_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial target.
// Assumes: A 200 MHz system clock.
// Notes: Definitions only.
`ifndef LTS_REGS_SVH
`define LTS_REGS_SVH

// ==========================================================================
// Bus identity and register map
// ==========================================================================
`define LTS_TARGET_ADDR 7'h4C
`define LTS_REG_LED_TEST 8'h0C
`define LTS_REG_CTRL 8'h00
`define LTS_SELF_TEST_START 8'h01
`define LTS_CTRL_RESET 8'h00
`define LTS_CTRL_STBY_BIT 6
`define LTS_CTRL_BOOST_BIT 3
`define LTS_TEST_RESET 8'h00
`define LTS_TEST_DONE_BIT 7
`define LTS_TEST_PASS_BIT 0

// ==========================================================================
// Timing
// ==========================================================================
`define LTS_CLK_MHZ 200
`define LTS_RESULT_SETTLE_US 10
`define LTS_RESULT_SETTLE_CYC (`LTS_RESULT_SETTLE_US * `LTS_CLK_MHZ)
`define LTS_LED_COUNT 4
`define LTS_STEP_BITS 3
`define LTS_SELF_TEST_SCL_EDGES 8'h10

`endif

// File: rtl/lts_pkg.sv
// Purpose: Types shared by the serial target and its test port.
// Assumes: Nothing beyond the register header.
// Notes: Types only.
package lts_pkg;

   // ==========================================================================
   // Bus and test port states, line samples and events, LED flags
   // ==========================================================================
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WRITE,
      ST_WRITE_ACK,
      ST_READ,
      ST_READ_ACK
   } lts_bus_state_e;

   typedef enum logic [1:0] {
      TP_WAIT,
      TP_SEQ,
      TP_DONE
   } lts_tp_state_e;

   typedef struct packed {
      logic scl;
      logic sda;
   } lts_line_s;

   typedef struct packed {
      logic rise;
      logic fall;
      logic start;
      logic stop;
   } lts_line_evt_s;

   typedef logic [3:0] lts_led_ok_t;

endpackage

// File: rtl/lts_test_port.sv
// Purpose: Pin-level LED connectivity test port driven by the stimulus pin.
// Assumes: Stimulus input already passed through a two-stage synchroniser.
// Notes: Runs from power-on reset only; the external reset pin has no effect here.
`timescale 1ns/100ps
`default_nettype none
`include "lts_regs.svh"

module lts_test_port (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_stim,
   input wire logic i_chip_ok,
   input wire lts_pkg::lts_led_ok_t i_led_ok,
   output logic o_result
);

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   lts_pkg::lts_tp_state_e state_q, state_d;
   logic stim_q, stim_d;
   logic [`LTS_STEP_BITS-1:0] step_q, step_d;
   logic result_q, result_d;
   logic rise;

   always_comb begin
      rise = i_stim & ~stim_q;
      state_d = state_q;
      step_d = step_q;
      stim_d = i_stim;
      result_d = 1'b0;
      case (state_q)
         lts_pkg::TP_WAIT: begin
            if (i_stim) begin
               result_d = i_chip_ok;
            end
            if (rise & i_chip_ok) begin
               state_d = lts_pkg::TP_SEQ;
               step_d = '0;
            end
         end
         lts_pkg::TP_SEQ: begin
            // Each later high phase reports one LED; the sixth high phase, the fifth after the acknowledging one, ends the test.
            if (rise) begin
               if (step_q == `LTS_STEP_BITS'(`LTS_LED_COUNT)) begin
                  state_d = lts_pkg::TP_DONE;
               end else begin
                  step_d = step_q + `LTS_STEP_BITS'(1);
               end
            end
            // The acknowledging high phase keeps showing the chip outcome.
            if (i_stim && step_q == '0) begin
               result_d = i_chip_ok;
            end else if (i_stim && step_q <= `LTS_STEP_BITS'(`LTS_LED_COUNT)) begin
               result_d = i_led_ok[step_q[1:0] - 2'h1];
            end
         end
         lts_pkg::TP_DONE: begin
            result_d = 1'b0;
         end
         default: begin
            state_d = lts_pkg::TP_WAIT;
         end
      endcase
   end

   // Result follows the stimulus within one clock plus synchroniser latency, far under 10 us.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= lts_pkg::TP_WAIT;
         step_q <= '0;
         stim_q <= 1'b0;
         result_q <= 1'b0;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
         stim_q <= stim_d;
         result_q <= result_d;
      end
   end

   assign o_result = result_q;

endmodule // lts_test_port
`default_nettype wire

// File: rtl/lts_serial_target.sv
// Purpose: Two-wire bus target at a fixed address with LED connectivity test port.
// Assumes: i_clk 200 MHz; SCL up to 400 kHz oversampled; i_rst is power-on reset.
// Notes: Open-drain data line as input, output and enable; output always low when enabled.
//
// What this block does
// - Data line changes only while clock low; sampled on clock high.
// - Data falling while clock high is a start condition.
// - Data rising while clock high is a stop condition.
// - A repeated start restarts address reception like a first start.
// - Bytes are eight bits, MSB first, then one acknowledge bit.
// - Transmitter releases data at acknowledge; receiver pulls it low on 9th clock.
// - The addressed receiver acknowledges every byte it receives.
// - First seven bits compared to address 4C; respond only on match.
// - Eighth bit 0 means write, 1 means read.
// - In a write, second byte is register index, third byte is data.
// - Bus logic works with clock rates up to 400 kHz.
// - Test port runs regardless of external reset pin.
// - Result output low while stimulus low.
// - Unpopulated test: stimulus high gives result 1 if functional.
// - Populated test: each later high phase reports one LED; last ends test.
// - Writing 01h to index 0Ch starts self-test; result read at 0Ch.
// - Stimulus phases at least 200 us; result valid within 10 us.
`timescale 1ns/100ps
`default_nettype none
`include "lts_regs.svh"

module lts_serial_target (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_external_reset_low,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic i_test_stimulus_in,
   input wire lts_pkg::lts_led_ok_t i_led_ok,
   input wire logic i_chip_ok,
   output logic o_test_result_out,
   output logic o_standby_release_bit,
   output logic o_boost_enable_bit
);

   // ==========================================================================
   // Input synchronisers
   // ==========================================================================
   logic [3:0] sync1_q, sync1_d;
   logic [3:0] sync2_q, sync2_d;
   lts_pkg::lts_line_s line_q, line_d;
   lts_pkg::lts_line_evt_s evt;
   logic stim_s, external_reset_low_s;

   always_comb begin
      sync1_d = {i_test_stimulus_in, i_external_reset_low, i_scl, i_sda};
      sync2_d = sync1_q;
      line_d.scl = sync2_q[1];
      line_d.sda = sync2_q[0];
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         // Idle pin levels: stimulus low, reset pin high, both bus lines high.
         // A stimulus stage reset high would show the test port a false edge.
         sync1_q <= 4'h7;
         sync2_q <= 4'h7;
         line_q <= '1;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         line_q <= line_d;
      end
   end

   assign stim_s = sync2_q[3];
   assign external_reset_low_s = sync2_q[2];

   // ==========================================================================
   // Line events
   // ==========================================================================
   // Clock edges at up to 400 kHz are seen hundreds of system cycles apart.
   always_comb begin
      evt.rise = sync2_q[1] & ~line_q.scl;
      evt.fall = ~sync2_q[1] & line_q.scl;
      evt.start = sync2_q[1] & line_q.scl & line_q.sda & ~sync2_q[0];
      evt.stop = sync2_q[1] & line_q.scl & ~line_q.sda & sync2_q[0];
   end

   // ==========================================================================
   // Transaction engine
   // ==========================================================================
   lts_pkg::lts_bus_state_e state_q, state_d;
   logic [7:0] shift_q, shift_d;
   logic [3:0] bit_q, bit_d;
   logic [7:0] index_q, index_d;
   logic have_index_q, have_index_d;
   logic rd_q, rd_d;
   logic drive_q, drive_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] test_q, test_d;
   logic [7:0] st_edges_q, st_edges_d;
   logic st_busy_q, st_busy_d;
   logic sda_out_q, sda_out_d;
   logic external_reset_low_soft_q;

   function automatic logic [7:0] reg_read(input logic [7:0] idx, input logic [7:0] ctrl,
                                           input logic [7:0] test);
      if (idx == `LTS_REG_LED_TEST) begin
         reg_read = test;
      end else if (idx == `LTS_REG_CTRL) begin
         reg_read = ctrl;
      end else begin
         reg_read = 8'h00;
      end
   endfunction

   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      bit_d = bit_q;
      index_d = index_q;
      have_index_d = have_index_q;
      rd_d = rd_q;
      drive_d = drive_q;
      ctrl_d = ctrl_q;
      test_d = test_q;
      st_edges_d = st_edges_q;
      st_busy_d = st_busy_q;
      sda_out_d = 1'b0;
      // Self-test is paced by bus clock edges, so a slow master gives it time.
      if (st_busy_q && evt.rise) begin
         if (st_edges_q == `LTS_SELF_TEST_SCL_EDGES) begin
            st_busy_d = 1'b0;
            test_d = 8'h00;
            test_d[`LTS_TEST_DONE_BIT] = 1'b1;
            test_d[`LTS_TEST_PASS_BIT] = (&i_led_ok) & ctrl_q[`LTS_CTRL_STBY_BIT]
                                         & ctrl_q[`LTS_CTRL_BOOST_BIT];
         end else begin
            st_edges_d = st_edges_q + 8'h01;
         end
      end
      if (evt.start) begin
         state_d = lts_pkg::ST_ADDR;
         bit_d = '0;
         drive_d = 1'b0;
         have_index_d = 1'b0;
      end else if (evt.stop) begin
         state_d = lts_pkg::ST_IDLE;
         drive_d = 1'b0;
      end else begin
         case (state_q)
            lts_pkg::ST_IDLE: begin
               drive_d = 1'b0;
            end
            lts_pkg::ST_ADDR, lts_pkg::ST_WRITE: begin
               if (evt.rise) begin
                  shift_d = {shift_q[6:0], line_q.sda};
                  bit_d = bit_q + 4'h1;
               end
               if (evt.fall && bit_q == 4'h8) begin
                  bit_d = '0;
                  if (state_q == lts_pkg::ST_ADDR) begin
                     if (shift_q[7:1] == `LTS_TARGET_ADDR) begin
                        rd_d = shift_q[0];
                        drive_d = 1'b1;
                        state_d = lts_pkg::ST_ADDR_ACK;
                     end else begin
                        state_d = lts_pkg::ST_IDLE;
                     end
                  end else begin
                     drive_d = 1'b1;
                     state_d = lts_pkg::ST_WRITE_ACK;
                     if (!have_index_q) begin
                        index_d = shift_q;
                        have_index_d = 1'b1;
                     end else begin
                        if (index_q == `LTS_REG_LED_TEST) begin
                           test_d = shift_q;
                           if (shift_q == `LTS_SELF_TEST_START) begin
                              st_busy_d = 1'b1;
                              st_edges_d = 8'h00;
                           end
                        end else if (index_q == `LTS_REG_CTRL) begin
                           ctrl_d = shift_q;
                        end
                        index_d = index_q + 8'h01;
                     end
                  end
               end
            end
            lts_pkg::ST_ADDR_ACK, lts_pkg::ST_WRITE_ACK: begin
               // Release, or the first read bit, follows the falling edge that ends the ninth clock.
               if (evt.fall) begin
                  bit_d = '0;
                  if (state_q == lts_pkg::ST_ADDR_ACK && rd_q) begin
                     shift_d = reg_read(index_q, ctrl_q, test_q);
                     drive_d = ~shift_d[7];
                     state_d = lts_pkg::ST_READ;
                  end else begin
                     drive_d = 1'b0;
                     state_d = lts_pkg::ST_WRITE;
                  end
               end
            end
            lts_pkg::ST_READ: begin
               if (evt.rise) begin
                  bit_d = bit_q + 4'h1;
               end
               if (evt.fall) begin
                  if (bit_q == 4'h8) begin
                     drive_d = 1'b0;
                     state_d = lts_pkg::ST_READ_ACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     drive_d = ~shift_q[6];
                  end
               end
            end
            lts_pkg::ST_READ_ACK: begin
               if (evt.rise) begin
                  if (line_q.sda) begin
                     state_d = lts_pkg::ST_IDLE;
                  end else begin
                     index_d = index_q + 8'h01;
                  end
               end
               if (evt.fall) begin
                  bit_d = '0;
                  shift_d = reg_read(index_q, ctrl_q, test_q);
                  drive_d = ~shift_d[7];
                  state_d = lts_pkg::ST_READ;
               end
            end
            default: begin
               state_d = lts_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= lts_pkg::ST_IDLE;
         shift_q <= 8'h00;
         bit_q <= 4'h0;
         index_q <= 8'h00;
         have_index_q <= 1'b0;
         rd_q <= 1'b0;
         drive_q <= 1'b0;
         ctrl_q <= `LTS_CTRL_RESET;
         test_q <= `LTS_TEST_RESET;
         st_edges_q <= 8'h00;
         st_busy_q <= 1'b0;
         sda_out_q <= 1'b0;
         external_reset_low_soft_q <= 1'b0;
      end else begin
         external_reset_low_soft_q <= ~external_reset_low_s;
         if (external_reset_low_soft_q) begin
            // The external reset pin clears only the bus side, never the test port.
            state_q <= lts_pkg::ST_IDLE;
            drive_q <= 1'b0;
            ctrl_q <= `LTS_CTRL_RESET;
            test_q <= `LTS_TEST_RESET;
            st_busy_q <= 1'b0;
            have_index_q <= 1'b0;
         end else begin
            state_q <= state_d;
            drive_q <= drive_d;
            ctrl_q <= ctrl_d;
            test_q <= test_d;
            st_busy_q <= st_busy_d;
            have_index_q <= have_index_d;
         end
         shift_q <= shift_d;
         bit_q <= bit_d;
         index_q <= index_d;
         rd_q <= rd_d;
         st_edges_q <= st_edges_d;
         sda_out_q <= sda_out_d;
      end
   end

   assign o_sda = sda_out_q;
   assign o_sda_oe = drive_q;
   assign o_standby_release_bit = ctrl_q[`LTS_CTRL_STBY_BIT];
   assign o_boost_enable_bit = ctrl_q[`LTS_CTRL_BOOST_BIT];

   // ==========================================================================
   // Pin-level test port
   // ==========================================================================
   lts_test_port u_test_port (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_stim(stim_s),
      .i_chip_ok(i_chip_ok),
      .i_led_ok(i_led_ok),
      .o_result(o_test_result_out)
   );

endmodule // lts_serial_target
`default_nettype wire

// File: testbench/lts_serial_target_assertions.sv
// Purpose: Concurrent checks on the pins of the serial target.
// Assumes: Bus pins sampled straight on i_clk; they move far slower than the clock.
// Notes: Bound to every instance of the target.
`timescale 1ns/100ps
`default_nettype none
`include "lts_regs.svh"
module lts_serial_target_assertions (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_external_reset_low,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda,
   input wire logic o_sda_oe,
   input wire logic i_test_stimulus_in,
   input wire lts_pkg::lts_led_ok_t i_led_ok,
   input wire logic i_chip_ok,
   input wire logic o_test_result_out,
   input wire logic o_standby_release_bit,
   input wire logic o_boost_enable_bit
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // ==========================================================================
   // Bus observer
   // ==========================================================================
   logic scl_q, sda_q, addr_q, ign_q;
   logic [3:0] cnt_q;
   logic [6:0] sh_q;
   wire logic start_w = scl_q && i_scl && sda_q && !i_sda;
   wire logic stop_w = scl_q && i_scl && !sda_q && i_sda;
   wire logic rise_w = !scl_q && i_scl;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         addr_q <= 1'b0;
         ign_q <= 1'b0;
         cnt_q <= 4'h0;
         sh_q <= 7'h00;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
         if (start_w) begin
            addr_q <= 1'b1;
            ign_q <= 1'b0;
            cnt_q <= 4'h0;
         end else if (stop_w) begin
            ign_q <= 1'b0;
         end else if (rise_w && addr_q) begin
            cnt_q <= cnt_q + 4'h1;
            sh_q <= {sh_q[5:0], i_sda};
            if (cnt_q == 4'h7) begin
               addr_q <= 1'b0;
               ign_q <= (sh_q != `LTS_TARGET_ADDR);
            end
         end
      end
   end
   sequence s_addr_seen;
      $fell(addr_q);
   endsequence
   sequence s_addr_ours;
      s_addr_seen ##0 !ign_q;
   endsequence
   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_drive_low_only: assert property (o_sda_oe |-> o_sda == 1'b0)
      else $error("data line driven high");
   a_addr_quiet: assert property (addr_q |-> !o_sda_oe)
      else $error("data line driven during address");
   a_addr_ack: assert property (s_addr_ours |-> ##[1:16] o_sda_oe)
      else $error("own address not acknowledged");
   a_foreign_silent: assert property (ign_q |-> !o_sda_oe)
      else $error("data line driven for foreign address");
   a_oe_hold_high: assert property ($rose(i_scl) |=> $stable(o_sda_oe)[*4])
      else $error("data drive moved while clock high");
   a_oe_move_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("data drive moved with clock high");
   a_result_low: assert property (!i_test_stimulus_in[*4] |-> !o_test_result_out)
      else $error("result high while stimulus low");
   a_result_fast: assert property ($fell(i_test_stimulus_in) |-> ##[1:4] !o_test_result_out)
      else $error("result slow to clear");
   a_result_cause: assert property ($rose(o_test_result_out) |->
      i_test_stimulus_in && $past(i_test_stimulus_in, 2))
      else $error("result rose without stimulus");
endmodule // lts_serial_target_assertions
bind lts_serial_target lts_serial_target_assertions lts_serial_target_assertions_inst (
   .i_clk, .i_rst, .i_external_reset_low, .i_scl, .i_sda, .o_sda, .o_sda_oe,
   .i_test_stimulus_in, .i_led_ok, .i_chip_ok, .o_test_result_out,
   .o_standby_release_bit, .o_boost_enable_bit);
`default_nettype wire

// File: testbench/lts_bus_master.sv
// Purpose: Behavioural two-wire bus master facing the serial target.
// Assumes: The bench resolves the open-drain data line with a pull-up.
// Notes: Clock stands high between frames; one bit takes 64 ns.
`timescale 1ns/100ps
`default_nettype none
module lts_bus_master (
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda
);
   localparam realtime QTR = 16.0;
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // Data moves a quarter bit after the clock falls, never while it is high.
   task automatic bit_xfer(input logic b, output logic s);
      #QTR o_sda = b;
      #QTR o_scl = 1'b1;
      #QTR s = i_sda;
      #QTR o_scl = 1'b0;
   endtask
   // The first wait lets the target release an acknowledge before data rises.
   task automatic start();
      #QTR o_sda = 1'b1;
      #QTR o_scl = 1'b1;
      #QTR o_sda = 1'b0;
      #QTR o_scl = 1'b0;
   endtask
   // The odd offset keeps every pin change away from the bench clock edges.
   task automatic open();
      #1.25;
      start();
   endtask
   task automatic stop();
      #QTR o_sda = 1'b0;
      #QTR o_scl = 1'b1;
      #QTR o_sda = 1'b1;
      #QTR;
   endtask
   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
      bit_xfer(1'b1, ack);
   endtask
   task automatic get(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
      bit_xfer(nack, s);
   endtask
endmodule // lts_bus_master
`default_nettype wire

// File: testbench/test_lts_serial_target.sv
// Purpose: Self-checking bench for the serial target and its test port.
// Assumes: 200 MHz clock; the master model sets the bus bit time.
// Notes: Stimulus phases are shortened to 20 cycles to keep the run short.
`timescale 1ns/100ps
`default_nettype none
`include "lts_regs.svh"
module test_lts_serial_target;
   localparam logic [7:0] CTRL_ON = (8'h01 << `LTS_CTRL_STBY_BIT) | (8'h01 << `LTS_CTRL_BOOST_BIT);
   localparam logic [7:0] DONE = 8'h01 << `LTS_TEST_DONE_BIT;
   localparam logic [7:0] PASS = 8'h01 << `LTS_TEST_PASS_BIT;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_external_reset_low = 1'b1;
   logic i_test_stimulus_in = 1'b0;
   logic i_chip_ok = 1'b1;
   lts_pkg::lts_led_ok_t i_led_ok = 4'hF;
   logic o_sda, o_sda_oe, o_test_result_out, o_standby_release_bit, o_boost_enable_bit;
   logic m_scl, m_sda;
   int num_errors = 0;
   int checks = 0;
   // Open-drain wire with pull-up: low when either party pulls it.
   wire logic sda_w = m_sda && !(o_sda_oe && !o_sda);
   lts_serial_target lts_serial_target_inst (.i_clk, .i_rst, .i_external_reset_low,
      .i_scl(m_scl), .i_sda(sda_w), .o_sda, .o_sda_oe, .i_test_stimulus_in, .i_led_ok,
      .i_chip_ok, .o_test_result_out, .o_standby_release_bit, .o_boost_enable_bit);
   lts_bus_master lts_bus_master_inst (.i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));
   initial forever #2.5 i_clk = ~i_clk;
   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("TB: %0d checks, %0d mismatches", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
      logic a;
      @(negedge i_clk);
      lts_bus_master_inst.open();
      lts_bus_master_inst.put({`LTS_TARGET_ADDR, 1'b0}, a);
      check("write address ack", 8'(a), 8'h00);
      lts_bus_master_inst.put(idx, a);
      check("index ack", 8'(a), 8'h00);
      lts_bus_master_inst.put(d, a);
      check("data ack", 8'(a), 8'h00);
      lts_bus_master_inst.stop();
   endtask
   task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
      logic a;
      @(negedge i_clk);
      lts_bus_master_inst.open();
      lts_bus_master_inst.put({`LTS_TARGET_ADDR, 1'b0}, a);
      lts_bus_master_inst.put(idx, a);
      lts_bus_master_inst.start();
      lts_bus_master_inst.put({`LTS_TARGET_ADDR, 1'b1}, a);
      check("read address ack", 8'(a), 8'h00);
      lts_bus_master_inst.get(1'b1, d);
      lts_bus_master_inst.stop();
   endtask
   task automatic phase(input logic exp);
      @(negedge i_clk);
      i_test_stimulus_in = 1'b1;
      repeat (20) @(negedge i_clk);
      check("result in high phase", 8'(o_test_result_out), 8'(exp));
      i_test_stimulus_in = 1'b0;
      repeat (20) @(negedge i_clk);
      check("result in low phase", 8'(o_test_result_out), 8'h00);
   endtask
   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_reset();
      logic [7:0] d;
      check("standby after reset", 8'(o_standby_release_bit), 8'h00);
      check("boost after reset", 8'(o_boost_enable_bit), 8'h00);
      reg_rd(`LTS_REG_LED_TEST, d);
      check("led test reset value", d, `LTS_TEST_RESET);
      $display("TB: reset values done");
   endtask
   task automatic t_ctrl();
      logic [7:0] d;
      reg_wr(`LTS_REG_CTRL, CTRL_ON);
      check("standby bit", 8'(o_standby_release_bit), 8'h01);
      check("boost bit", 8'(o_boost_enable_bit), 8'h01);
      reg_rd(`LTS_REG_CTRL, d);
      check("control readback", d, CTRL_ON);
      reg_wr(8'h33, 8'h5A);
      reg_rd(8'h33, d);
      check("unmapped readback", d, 8'h00);
      $display("TB: register access done");
   endtask
   task automatic t_miss();
      logic a;
      logic [6:0] bad [2] = '{7'h4D, 7'h0C};
      for (int i = 0; i < 2; i++) begin
         @(negedge i_clk);
         lts_bus_master_inst.open();
         lts_bus_master_inst.put({bad[i], 1'b0}, a);
         check("foreign address ack", 8'(a), 8'h01);
         lts_bus_master_inst.put(`LTS_REG_CTRL, a);
         check("foreign index ack", 8'(a), 8'h01);
         lts_bus_master_inst.put(8'h00, a);
         lts_bus_master_inst.stop();
      end
      check("control kept", 8'(o_standby_release_bit), 8'h01);
      $display("TB: foreign address done");
   endtask
   task automatic t_self();
      logic [7:0] d;
      for (int i = 0; i < 2; i++) begin
         @(negedge i_clk);
         i_led_ok = (i == 0) ? 4'hF : 4'hB;
         // The self-test counts bus clock edges, so a fast bit time only shortens it.
         reg_wr(`LTS_REG_LED_TEST, `LTS_SELF_TEST_START);
         reg_rd(`LTS_REG_LED_TEST, d);
         check("self-test outcome", d, (i == 0) ? (DONE | PASS) : DONE);
      end
      $display("TB: bus self-test done");
   endtask
   // The pin reset is held low throughout: the port must not care.
   task automatic t_port();
      @(negedge i_clk);
      i_external_reset_low = 1'b0;
      i_led_ok = 4'h5;
      repeat (8) @(negedge i_clk);
      check("control under pin reset", 8'(o_standby_release_bit), 8'h00);
      phase(i_chip_ok);
      for (int i = 0; i < 4; i++) phase(i_led_ok[i]);
      phase(1'b0);
      phase(1'b0);
      i_external_reset_low = 1'b1;
      $display("TB: test port done");
   endtask
   initial begin
      repeat (16) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (8) @(negedge i_clk);
      t_reset();
      t_ctrl();
      t_miss();
      t_self();
      t_port();
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge i_clk);
      num_errors++;
      stop_test();
   end
endmodule // test_lts_serial_target
`default_nettype wire
